// ### pkg/clock_ctrl_map.svh
// Purpose: Offsets, field positions, reset values and divide figures of the clock and sleep control block
// Assumes: Included by bare name from the design and bench files
// Notes  : Definitions only
`ifndef CLOCK_CTRL_MAP_SVH
`define CLOCK_CTRL_MAP_SVH

// I/O ports of the indexed register access and the speed ports
`define INDEX_PORT      16'h00EC
`define DATA_PORT       16'h00ED
`define SLOW_SPEED_PORT 16'h00F4
`define FAST_SPEED_PORT 16'h00F5

// Register indexes behind the data port, and the value read back from an unmapped index
`define CLK_REG_IDX     8'h07
`define SLEEP_REG_IDX   8'h13
`define MISC_IDX        8'h14
`define UNMAPPED_DATA   8'hFF

// Clock control register fields
`define VIDEO_EN_BIT    7
`define CPU_DIV_HI      6
`define CPU_DIV_LO      5
`define FAST_DIV_HI     4
`define FAST_DIV_LO     3
`define OSC_SENSE_BIT   2
`define SLOW_DIV_HI     1
`define SLOW_DIV_LO     0

// Sleep control register fields, and the pin mode bit of the misc setup register
`define SLEEP_REQ_BIT   7
`define SLEEP_CODE_HI   6
`define SLEEP_CODE_LO   3
`define PIN_STATUS_BIT  2
`define PIN_FUNC_BIT    1
`define ENSYSCK_BIT     0
`define PIN_MODE_BIT    0

// Reset values
`define VIDEO_EN_RST    1'b0
`define CPU_DIV_RST     2'h0
`define FAST_DIV_RST    2'h2
`define SLEEP_CODE_RST  4'h0
`define PIN_FUNC_RST    1'b0
`define ENSYSCK_RST     1'b1
`define PIN_MODE_RST    1'b0

// Video memory window, 128 KB of the 16 MB address space
`define VIDEO_LO        24'h0A0000
`define VIDEO_HI        24'h0BFFFF

// Sleep divide factors by code, 0001 and codes above 1000 are reserved
`define SLEEP_DIV_0     11'h001
`define SLEEP_DIV_2     11'h008
`define SLEEP_DIV_3     11'h00C
`define SLEEP_DIV_4     11'h010
`define SLEEP_DIV_5     11'h040
`define SLEEP_DIV_6     11'h080
`define SLEEP_DIV_7     11'h100
`define SLEEP_DIV_8     11'h400

`endif

// ### pkg/clock_ctrl_pkg.sv
// Purpose: Types shared by the clock and sleep control modules
// Assumes: Nothing beyond the map header
// Notes  : Sleep states are one-hot
package clock_ctrl_pkg;
	typedef logic [10:0] div_t;

	typedef enum logic [2:0] {
		ST_AWAKE = 3'b001,
		ST_SLEEP = 3'b010,
		ST_HOLD  = 3'b100
	} sleep_state_t;
endpackage : clock_ctrl_pkg

// ### pkg/div_if.sv
// Purpose: Carrier between the control logic and one clock divider
// Assumes: Single clock domain
// Notes  : divisor is a toggle count in source ticks
`timescale 1ns/100ps
`default_nettype none
interface div_if;
	clock_ctrl_pkg::div_t divisor;
	logic                 tick;
	logic                 clk_out;

	modport ctrl (output divisor, output tick, input clk_out);
	modport gen  (input divisor, input tick, output clk_out);
endinterface : div_if
`default_nettype wire

// ### verilog/clock_div_gen.sv
// Purpose: Divided clock waveform with glitch-free divisor changes
// Assumes: tick marks one source edge; divisor of 1 or more
// Notes  : A new divisor is taken only at the start of a high phase
`timescale 1ns/100ps
`default_nettype none
module clock_div_gen (
	// Clock and reset
	input  wire logic CLK,
	input  wire logic RST_N,
	// Divider carrier
	div_if.gen        dv
);
	import clock_ctrl_pkg::*;

	div_t cnt_q;
	div_t cur_div_q;
	logic out_q;

	////////////////////////////////////////////////////////////////////////
	// whole phases only
	// Count ticks, toggle after cur_div of them; reload only on the rising toggle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_q     <= 11'h000;
			cur_div_q <= 11'h001;
			out_q     <= 1'b0;
		end else if (dv.tick) begin
			if (cnt_q >= cur_div_q - 11'h001) begin
				cnt_q <= 11'h000;
				out_q <= ~out_q;
				if (!out_q) begin
					cur_div_q <= (dv.divisor == 11'h000) ? 11'h001 : dv.divisor;
				end
			end else begin
				cnt_q <= cnt_q + 11'h001;
			end
		end
	end

	assign dv.clk_out = out_q;

	////////////////////////////////////////////////////////////////////////
	// A changed divisor only ever lands together with a rising output
	a_div_reload_edge: assert property (@(posedge CLK) disable iff (!RST_N)
		$changed(cur_div_q) |-> $rose(out_q))
		else $error("divisor changed outside a period boundary");

	// Output never toggles before the current count is used up
	a_no_short_phase: assert property (@(posedge CLK) disable iff (!RST_N)
		($changed(out_q) && $past(cur_div_q) > 11'h001) |-> $past(cnt_q) != 11'h000)
		else $error("clock phase shorter than divisor");
endmodule : clock_div_gen
`default_nettype wire

// ### verilog/clock_divider_sleep_control.sv
// Purpose: Processor and bus clock dividers with sleep mode control
// Assumes: Each CLK cycle stands for one half-cycle of the 2x processor input clock
// Notes  : Registers sit behind an index port and a data port on the I/O bus
`timescale 1ns/100ps
`default_nettype none
`include "clock_ctrl_map.svh"

module clock_divider_sleep_control (
	// Clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	// I/O register access
	input  wire logic [15:0]           IO_ADDR,
	input  wire logic [7:0]            IO_WDATA,
	input  wire logic                  IO_WR,
	input  wire logic                  IO_RD,
	output logic      [7:0]            IO_RDATA,
	// Memory cycle watch
	input  wire logic                  MEM_CYCLE,
	input  wire logic [23:0]           MEM_ADDR,
	// Pins and straps
	input  wire logic                  TURBO,
	input  wire logic                  BUS_OSC_IN,
	input  wire logic                  BUS_OSC_PRESENT,
	input  wire logic                  STRAP_HI,
	input  wire logic                  STRAP_LO,
	input  wire logic                  SLEEP_N,
	input  wire logic                  IRQ,
	input  wire logic                  HOLD_REQ,
	// Clocks and sleep status
	output logic                       CPU_CLK_OUT,
	output logic                       BUS_CLK_OUT,
	output logic                       SLEEP_ACTIVE,
	output logic                       OSC_LOGIC_EN,
	output logic                       REFRESH_DIV_EN,
	output clock_ctrl_pkg::div_t       CPU_DIV_NOW
);
	import clock_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Divide figure lookups
	function automatic div_t sleep_div(input logic [3:0] code);
		case (code)
			4'h0:    sleep_div = `SLEEP_DIV_0;
			4'h2:    sleep_div = `SLEEP_DIV_2;
			4'h3:    sleep_div = `SLEEP_DIV_3;
			4'h4:    sleep_div = `SLEEP_DIV_4;
			4'h5:    sleep_div = `SLEEP_DIV_5;
			4'h6:    sleep_div = `SLEEP_DIV_6;
			4'h7:    sleep_div = `SLEEP_DIV_7;
			4'h8:    sleep_div = `SLEEP_DIV_8;
			default: sleep_div = `SLEEP_DIV_0; // Reserved codes run undivided
		endcase
	endfunction : sleep_div

	// Toggle count for a bus divide factor; an oscillator tick is a whole period
	function automatic div_t bus_div(input logic [3:0] factor, input logic osc);
		bus_div = osc ? div_t'(factor >> 1) : div_t'(factor);
	endfunction : bus_div

	////////////////////////////////////////////////////////////////////////
	// State
	logic         video_en_q;
	logic [1:0]   cpu_sel_q;
	logic [1:0]   fast_sel_q;
	logic         sense_q;
	logic [1:0]   slow_sel_q;
	logic         sleep_req_q;
	logic [3:0]   sleep_code_q;
	logic         pin_func_q;
	logic         ensysck_q;
	logic         pin_mode_q;
	logic [7:0]   index_q;
	logic         nonturbo_q;
	logic         osc_present_q;
	logic         strap_done_q;
	logic         pin_prev_q;
	logic         osc_prev_q;
	logic [7:0]   rdata_q;
	sleep_state_t state_q;
	sleep_state_t state_d;
	div_t         cpu_div_q;
	div_t         bus_div_q;
	logic         bus_tick_q;
	logic         osc_en_q;
	logic         refresh_en_q;

	// Decoded strobes
	logic wr_index;
	logic wr_data;
	logic wr_clk;
	logic wr_sleep;
	logic wr_misc;
	logic pin_fall;
	logic pin_rise;
	logic enter_sleep;
	logic exit_sleep;
	logic video_hit;
	logic fast_use;
	logic nonturbo_sel;

	div_if cpu_dv ();
	div_if bus_dv ();

	////////////////////////////////////////////////////////////////////////
	// Address decoding of the index and data ports
	always_comb begin
		wr_index = 1'b0;
		wr_data  = 1'b0;
		if (IO_WR && IO_ADDR == `INDEX_PORT) begin
			wr_index = 1'b1;
		end else if (IO_WR && IO_ADDR == `DATA_PORT) begin
			wr_data = 1'b1;
		end
	end

	assign wr_clk   = wr_data && (index_q == `CLK_REG_IDX);
	assign wr_sleep = wr_data && (index_q == `SLEEP_REG_IDX);
	assign wr_misc  = wr_data && (index_q == `MISC_IDX);

	// Index register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			index_q <= 8'h00;
		end else if (wr_index) begin
			index_q <= IO_WDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Straps are caught on the first edge after release, never under reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_done_q  <= 1'b0;
			osc_present_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q  <= 1'b1;
			osc_present_q <= BUS_OSC_PRESENT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock control register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			video_en_q <= `VIDEO_EN_RST;
			cpu_sel_q  <= `CPU_DIV_RST;
			fast_sel_q <= `FAST_DIV_RST;
			sense_q    <= 1'b0;
			slow_sel_q <= 2'h0;
		end else if (!strap_done_q) begin
			slow_sel_q <= {STRAP_HI, STRAP_LO};
			sense_q    <= BUS_OSC_PRESENT ? 1'b0 : BUS_OSC_IN;
		end else begin
			if (wr_clk) begin
				video_en_q <= IO_WDATA[`VIDEO_EN_BIT];
				cpu_sel_q  <= IO_WDATA[`CPU_DIV_HI:`CPU_DIV_LO];
				fast_sel_q <= IO_WDATA[`FAST_DIV_HI:`FAST_DIV_LO];
				slow_sel_q <= IO_WDATA[`SLOW_DIV_HI:`SLOW_DIV_LO];
			end
			// sense mirrors pin or holds software value
			if (!osc_present_q) begin
				sense_q <= BUS_OSC_IN;
			end else if (wr_clk) begin
				sense_q <= IO_WDATA[`OSC_SENSE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep control and misc setup registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sleep_req_q  <= 1'b0;
			sleep_code_q <= `SLEEP_CODE_RST;
			pin_func_q   <= `PIN_FUNC_RST;
			ensysck_q    <= `ENSYSCK_RST;
			pin_mode_q   <= `PIN_MODE_RST;
		end else begin
			if (wr_sleep) begin
				sleep_req_q  <= IO_WDATA[`SLEEP_REQ_BIT];
				sleep_code_q <= IO_WDATA[`SLEEP_CODE_HI:`SLEEP_CODE_LO];
				pin_func_q   <= IO_WDATA[`PIN_FUNC_BIT];
				ensysck_q    <= IO_WDATA[`ENSYSCK_BIT];
			end
			if (wr_misc) begin
				pin_mode_q <= IO_WDATA[`PIN_MODE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software slow-speed latch; F5h write returns to turbo
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			nonturbo_q <= 1'b0;
		end else if (IO_WR && IO_ADDR == `SLOW_SPEED_PORT) begin
			nonturbo_q <= 1'b1;
		end else if (IO_WR && IO_ADDR == `FAST_SPEED_PORT) begin
			nonturbo_q <= 1'b0;
		end
	end

	// Pin history for edge detection; SLEEP_N history resets idle-high so reset makes no edge, oscillator history resets low
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_prev_q <= 1'b1;
			osc_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= SLEEP_N;
			osc_prev_q <= BUS_OSC_IN;
		end
	end

	assign pin_fall = pin_prev_q && !SLEEP_N;
	assign pin_rise = !pin_prev_q && SLEEP_N;

	////////////////////////////////////////////////////////////////////////
	// Sleep entry and exit; exit wins when both land together
	// pin entry
	assign enter_sleep = (wr_sleep && IO_WDATA[`SLEEP_REQ_BIT]) || (pin_func_q && pin_fall);
	assign exit_sleep  = (wr_sleep && !IO_WDATA[`SLEEP_REQ_BIT]) || (pin_rise && !pin_mode_q) || IRQ;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_AWAKE: begin
				if (enter_sleep && !exit_sleep) begin
					state_d = HOLD_REQ ? ST_HOLD : ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (exit_sleep) begin
					state_d = ST_AWAKE;
				end else if (HOLD_REQ) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (exit_sleep) begin
					state_d = ST_AWAKE;
				end else if (!HOLD_REQ) begin
					state_d = ST_SLEEP;
				end
			end
			default: state_d = ST_AWAKE;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_AWAKE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Processor divisor; the divider itself waits for a period boundary
	assign nonturbo_sel = !TURBO || nonturbo_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cpu_div_q <= 11'h001;
		end else if (state_d == ST_SLEEP) begin
			cpu_div_q <= sleep_div(sleep_code_q);
		end else if (nonturbo_sel) begin
			cpu_div_q <= div_t'(cpu_sel_q) + 11'h001;
		end else begin
			cpu_div_q <= 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus divisor and source tick
	assign video_hit = (MEM_ADDR >= `VIDEO_LO) && (MEM_ADDR <= `VIDEO_HI);
	assign fast_use  = sense_q || (video_en_q && MEM_CYCLE && video_hit);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bus_div_q <= 11'h002;
		end else if (fast_use) begin
			// fast factors, reserved code runs as divide by 6
			bus_div_q <= bus_div((fast_sel_q == 2'h0) ? 4'h2 : (fast_sel_q == 2'h1) ? 4'h4 : 4'h6,
			                     osc_present_q);
		end else begin
			bus_div_q <= bus_div({1'b0, slow_sel_q, 1'b0} + 4'h2, osc_present_q);
		end
	end

	// source: oscillator rising edges, or every input half-cycle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bus_tick_q <= 1'b0;
		end else begin
			bus_tick_q <= osc_present_q ? (BUS_OSC_IN && !osc_prev_q) : 1'b1;
		end
	end

	assign cpu_dv.divisor = cpu_div_q;
	assign cpu_dv.tick    = 1'b1;
	assign bus_dv.divisor = bus_div_q;
	assign bus_dv.tick    = bus_tick_q;

	clock_div_gen u_cpu_div (
		.CLK   (CLK),
		.RST_N (RST_N),
		.dv    (cpu_dv)
	);

	clock_div_gen u_bus_div (
		.CLK   (CLK),
		.RST_N (RST_N),
		.dv    (bus_dv)
	);

	////////////////////////////////////////////////////////////////////////
	// sleep gating outputs; bus clock keeps running for DMA and refresh
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			osc_en_q     <= 1'b1;
			refresh_en_q <= 1'b0;
		end else begin
			osc_en_q     <= (state_d != ST_SLEEP);
			refresh_en_q <= (state_d == ST_SLEEP);
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 8'h00;
		end else if (IO_RD) begin
			if (IO_ADDR == `INDEX_PORT) begin
				rdata_q <= index_q;
			end else if (IO_ADDR == `DATA_PORT && index_q == `CLK_REG_IDX) begin
				rdata_q <= {video_en_q, cpu_sel_q, fast_sel_q, sense_q, slow_sel_q};
			end else if (IO_ADDR == `DATA_PORT && index_q == `SLEEP_REG_IDX) begin
				rdata_q <= {sleep_req_q, sleep_code_q, pin_prev_q, pin_func_q, ensysck_q};
			end else if (IO_ADDR == `DATA_PORT && index_q == `MISC_IDX) begin
				rdata_q <= {7'h00, pin_mode_q};
			end else begin
				rdata_q <= `UNMAPPED_DATA;
			end
		end
	end

	assign IO_RDATA       = rdata_q;
	assign CPU_CLK_OUT    = cpu_dv.clk_out;
	assign BUS_CLK_OUT    = bus_dv.clk_out;
	assign SLEEP_ACTIVE   = state_q[1];
	assign OSC_LOGIC_EN   = osc_en_q;
	assign REFRESH_DIV_EN = refresh_en_q;
	assign CPU_DIV_NOW    = cpu_div_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_sleep_write(bit val);
		wr_sleep && IO_WDATA[`SLEEP_REQ_BIT] == val;
	endsequence

	sequence s_pin_fall_armed;
		pin_func_q && pin_fall && !exit_sleep && !HOLD_REQ;
	endsequence

	a_video_fast_pick: assert property (@(posedge CLK) disable iff (!RST_N)
		(strap_done_q && !sense_q && video_en_q && MEM_CYCLE && video_hit && !osc_present_q && fast_sel_q == 2'h0)
		|=> bus_div_q == 11'h002)
		else $error("video access did not pick fast divider");

	a_turbo_full_speed: assert property (@(posedge CLK) disable iff (!RST_N)
		(TURBO && !nonturbo_q && state_d == ST_AWAKE) |=> cpu_div_q == 11'h001)
		else $error("turbo mode not undivided");

	a_nonturbo_div: assert property (@(posedge CLK) disable iff (!RST_N)
		(!TURBO && state_d != ST_SLEEP) |=> cpu_div_q == div_t'($past(cpu_sel_q)) + 11'h001)
		else $error("non-turbo divider wrong");

	a_strap_load: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(strap_done_q) |-> slow_sel_q == {$past(STRAP_HI), $past(STRAP_LO)})
		else $error("strap pins not loaded");

	a_sense_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
		(strap_done_q && !osc_present_q) |=> sense_q == $past(BUS_OSC_IN))
		else $error("sense bit does not mirror pin");

	a_pin_enter: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == ST_AWAKE) ##0 s_pin_fall_armed |=> state_q == ST_SLEEP)
		else $error("pin fall did not enter sleep");

	a_soft_enter: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == ST_AWAKE && !IRQ && !HOLD_REQ && !pin_rise) ##0 s_sleep_write(1'b1)
		|=> state_q == ST_SLEEP ##1 cpu_div_q == sleep_div($past(sleep_code_q)))
		else $error("software sleep entry failed");

	a_irq_exit: assert property (@(posedge CLK) disable iff (!RST_N)
		IRQ |=> state_q == ST_AWAKE ##1 (osc_en_q && !refresh_en_q))
		else $error("interrupt did not end sleep");

	a_hold_suspend: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == ST_SLEEP && HOLD_REQ && !exit_sleep) |=> state_q == ST_HOLD ##0 osc_en_q)
		else $error("hold did not suspend sleep divider");

	a_hold_resume: assert property (@(posedge CLK) disable iff (!RST_N)
		(state_q == ST_HOLD && !HOLD_REQ && !exit_sleep) |=> state_q == ST_SLEEP)
		else $error("sleep not resumed after hold");
endmodule : clock_divider_sleep_control
`default_nettype wire

// ### verification/bus_osc_model.sv
// Purpose: Bus oscillator pin source for the clock block
// Assumes: Steps on CLK rising edges
// Notes  : Holds a level when not running, as an unconnected pin would
`timescale 1ns/100ps
`default_nettype none
module bus_osc_model #(
	parameter int HALF = 3
) (
	// Clock
	input  wire logic CLK,
	// Control
	input  wire logic run,
	input  wire logic level,
	// Pin
	output logic      osc_pin
);
	int cnt = 0;

	always @(posedge CLK) begin
		if (!run) begin
			osc_pin <= level;
			cnt     <= 0;
		end else if (cnt == HALF - 1) begin
			osc_pin <= ~osc_pin;
			cnt     <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : bus_osc_model
`default_nettype wire

// ### verification/clock_divider_sleep_control_bench.sv
// Purpose: Self-checking bench of the clock and sleep control block
// Assumes: Bus oscillator half period of 3 CLK in the model
// Notes  : Periods are counted in CLK cycles between rising edges
`timescale 1ns/100ps
`default_nettype none
`include "clock_ctrl_map.svh"
module clock_divider_sleep_control_bench;
	logic                 CLK = 0, RST_N = 0, IO_WR = 0, IO_RD = 0, MEM_CYCLE = 0, TURBO = 1;
	logic                 osc_run = 0, osc_lvl = 1, BUS_OSC_PRESENT = 0, STRAP_HI = 1, STRAP_LO = 0;
	logic                 SLEEP_N = 1, IRQ = 0, HOLD_REQ = 0, BUS_OSC_IN, CPU_CLK_OUT, BUS_CLK_OUT;
	logic                 SLEEP_ACTIVE, OSC_LOGIC_EN, REFRESH_DIV_EN;
	logic [15:0]          IO_ADDR = 0;
	logic [7:0]           IO_WDATA = 0, IO_RDATA;
	logic [23:0]          MEM_ADDR = 0;
	clock_ctrl_pkg::div_t CPU_DIV_NOW;
	int                   bad_count = 0, n_checks = 0;

	always #20 CLK = ~CLK;

	clock_divider_sleep_control uut (.CLK, .RST_N, .IO_ADDR, .IO_WDATA, .IO_WR, .IO_RD, .IO_RDATA,
		.MEM_CYCLE, .MEM_ADDR, .TURBO, .BUS_OSC_IN, .BUS_OSC_PRESENT, .STRAP_HI, .STRAP_LO, .SLEEP_N,
		.IRQ, .HOLD_REQ, .CPU_CLK_OUT, .BUS_CLK_OUT, .SLEEP_ACTIVE, .OSC_LOGIC_EN, .REFRESH_DIV_EN,
		.CPU_DIV_NOW);
	bus_osc_model osc (.CLK, .run(osc_run), .level(osc_lvl), .osc_pin(BUS_OSC_IN));

	////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One write strobe, released on the edge that takes it
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		IO_ADDR  <= a;
		IO_WDATA <= d;
		IO_WR    <= 1'b1;
		@(posedge CLK);
		IO_WR <= 1'b0;
	endtask : wr
	task wreg(input logic [7:0] i, input logic [7:0] d);
		wr(`INDEX_PORT, i);
		wr(`DATA_PORT, d);
	endtask : wreg
	task rreg(input logic [7:0] i, output logic [7:0] d);
		wr(`INDEX_PORT, i);
		@(posedge CLK);
		IO_ADDR <= `DATA_PORT;
		IO_RD   <= 1'b1;
		@(posedge CLK);
		IO_RD <= 1'b0;
		@(negedge CLK);
		d = IO_RDATA;
	endtask : rreg
	// Sample on falling edges so registered outputs have settled
	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask : cyc
	// Skips one period so a divisor taken at a rise is in force
	task per(input bit sel, output int n);
		int   k, r;
		logic p, c;
		n = 0;
		r = 0;
		p = 1'b1;
		for (k = 0; k < 400 && r < 3; k++) begin
			@(negedge CLK);
			c = sel ? BUS_CLK_OUT : CPU_CLK_OUT;
			if (c === 1'b1 && p === 1'b0) r++;
			if (r == 2) n++;
			p = c;
		end
	endtask : per
	task pulse_irq;
		@(posedge CLK);
		IRQ <= 1'b1;
		@(posedge CLK);
		IRQ <= 1'b0;
		cyc(2);
	endtask : pulse_irq
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////
	task t_reset;
		logic [7:0] d;
		chk({SLEEP_ACTIVE, OSC_LOGIC_EN, REFRESH_DIV_EN}, 3'b010);
		chk(CPU_DIV_NOW, 11'h001);
		rreg(`CLK_REG_IDX, d);
		chk(d, 8'h16);
		rreg(`SLEEP_REG_IDX, d);
		chk(d & 8'hFB, 8'h01);
		rreg(8'h30, d);
		chk(d, `UNMAPPED_DATA);
		// Sense bit is read-only while no oscillator is wired
		wreg(`CLK_REG_IDX, 8'h12);
		rreg(`CLK_REG_IDX, d);
		chk(d, 8'h16);
		$display("test reset done");
	endtask : t_reset

	task t_cpu;
		int c, n;
		@(posedge CLK) TURBO <= 1'b0;
		for (c = 0; c < 4; c++) begin
			wreg(`CLK_REG_IDX, {1'b0, c[1:0], 5'b10010});
			cyc(2);
			chk(CPU_DIV_NOW, c + 1);
			per(0, n);
			chk(n, 2 * (c + 1));
		end
		@(posedge CLK) TURBO <= 1'b1;
		cyc(3);
		chk(CPU_DIV_NOW, 11'h001);
		wr(`SLOW_SPEED_PORT, 8'h00);
		cyc(2);
		chk(CPU_DIV_NOW, 11'h004);
		wr(`FAST_SPEED_PORT, 8'h00);
		cyc(2);
		chk(CPU_DIV_NOW, 11'h001);
		@(posedge CLK) TURBO <= 1'b0;
		$display("test cpu done");
	endtask : t_cpu

	task t_bus;
		int s, n;
		@(posedge CLK) osc_lvl <= 1'b0;
		for (s = 0; s < 4; s++) begin
			wreg(`CLK_REG_IDX, {5'b01100, s[2:0]});
			per(1, n);
			chk(n, 4 * (s + 1));
		end
		@(posedge CLK) osc_lvl <= 1'b1;
		for (s = 0; s < 3; s++) begin
			wreg(`CLK_REG_IDX, {3'b011, s[1:0], 3'b011});
			per(1, n);
			chk(n, 4 * (s + 1));
		end
		// Video window edges with fast /2 against slow /8
		@(posedge CLK) osc_lvl <= 1'b0;
		wreg(`CLK_REG_IDX, 8'hE3);
		MEM_CYCLE <= 1'b1;
		MEM_ADDR  <= `VIDEO_HI;
		per(1, n);
		chk(n, 4);
		@(posedge CLK) MEM_ADDR <= 24'h09FFFF;
		per(1, n);
		chk(n, 16);
		@(posedge CLK) MEM_ADDR <= `VIDEO_LO;
		wreg(`CLK_REG_IDX, 8'h63);
		per(1, n);
		chk(n, 16);
		@(posedge CLK) MEM_CYCLE <= 1'b0;
		$display("test bus done");
	endtask : t_bus

	task t_sleep;
		int i, n;
		logic [3:0] cd[8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
		clock_ctrl_pkg::div_t tab[8] = '{`SLEEP_DIV_0, `SLEEP_DIV_2, `SLEEP_DIV_3, `SLEEP_DIV_4,
			`SLEEP_DIV_5, `SLEEP_DIV_6, `SLEEP_DIV_7, `SLEEP_DIV_8};
		for (i = 0; i < 8; i++) begin
			wreg(`SLEEP_REG_IDX, {1'b1, cd[i], 3'b000});
			cyc(2);
			chk(CPU_DIV_NOW, tab[i]);
			wreg(`SLEEP_REG_IDX, 8'h00);
		end
		// fields set once, then only bit 7 toggles
		wreg(`SLEEP_REG_IDX, 8'h10);
		// bus left idle after the sleep write, as a halted processor
		wreg(`SLEEP_REG_IDX, 8'h90);
		cyc(2);
		chk({SLEEP_ACTIVE, OSC_LOGIC_EN, REFRESH_DIV_EN}, 3'b101);
		per(0, n);
		chk(n, 16);
		@(posedge CLK) TURBO <= 1'b1;
		cyc(3);
		chk(CPU_DIV_NOW, `SLEEP_DIV_2);
		@(posedge CLK) HOLD_REQ <= 1'b1;
		cyc(3);
		chk({SLEEP_ACTIVE, CPU_DIV_NOW}, 12'h001);
		@(posedge CLK) HOLD_REQ <= 1'b0;
		cyc(3);
		chk({SLEEP_ACTIVE, CPU_DIV_NOW}, {1'b1, `SLEEP_DIV_2});
		pulse_irq;
		chk({SLEEP_ACTIVE, OSC_LOGIC_EN, REFRESH_DIV_EN}, 3'b010);
		chk(CPU_DIV_NOW, 11'h001);
		wreg(`SLEEP_REG_IDX, 8'h90);
		wreg(`SLEEP_REG_IDX, 8'h10);
		cyc(2);
		chk(SLEEP_ACTIVE, 1'b0);
		$display("test sleep done");
	endtask : t_sleep

	task t_pin(input logic [7:0] ctl, input logic [7:0] mode, input logic in_exp, input logic out_exp);
		wreg(`SLEEP_REG_IDX, ctl);
		wreg(`MISC_IDX, mode);
		@(posedge CLK) SLEEP_N <= 1'b0;
		cyc(4);
		chk(SLEEP_ACTIVE, in_exp);
		@(posedge CLK) SLEEP_N <= 1'b1;
		cyc(4);
		chk(SLEEP_ACTIVE, out_exp);
		pulse_irq;
		$display("test pin done");
	endtask : t_pin

	task t_osc;
		int n;
		logic [7:0] d;
		wreg(`SLEEP_REG_IDX, 8'h90);
		@(posedge CLK);
		RST_N           <= 1'b0;
		BUS_OSC_PRESENT <= 1'b1;
		STRAP_HI        <= 1'b0;
		STRAP_LO        <= 1'b1;
		osc_run         <= 1'b1;
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		cyc(1);
		chk(SLEEP_ACTIVE, 1'b0);
		rreg(`CLK_REG_IDX, d);
		chk(d, 8'h11);
		per(1, n);
		chk(n, 24);
		wreg(`CLK_REG_IDX, 8'h14);
		rreg(`CLK_REG_IDX, d);
		chk(d, 8'h14);
		per(1, n);
		chk(n, 36);
		$display("test osc done");
	endtask : t_osc

	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		// Look at outputs between edges, never in the edge's own time step
		cyc(2);
		t_reset;
		t_cpu;
		t_bus;
		t_sleep;
		t_pin(8'h10, 8'h00, 1'b0, 1'b0);
		t_pin(8'h12, 8'h00, 1'b1, 1'b0);
		t_pin(8'h12, 8'h01, 1'b1, 1'b1);
		t_osc;
		give_verdict;
	end
	// Watchdog well past the expected run length
	initial begin
		#2000000;
		bad_count++;
		give_verdict;
	end
endmodule : clock_divider_sleep_control_bench
`default_nettype wire
